//--- testbench/e1rx_sys_model.sv
`timescale 1ns/100ps
module e1rx_sys_model
(
	input wire logic clk,
	input wire logic rclk,
	input wire logic rd,
	input wire logic cv,
	output int ones,
	output int errs
);
	logic rclk_q;
	initial
	begin
		ones = 0;
		errs = 0;
		rclk_q = 1'h0;
	end
	// sample on the falling edge, opposite to the rising launch edge
	always @(posedge clk)
	begin
		rclk_q <= rclk;
		if (rclk_q && !rclk)
		begin
			ones <= ones + int'(rd);
			errs <= errs + int'(cv);
		end
	end
endmodule

//--- testbench/e1rx_top_tb.sv
`timescale 1ns/100ps
module e1rx_top_tb;
	import e1rx_pkg::*;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	e1rx_addr_t reg_addr = 8'h00;
	e1rx_word_t reg_wdata = 32'h0;
	e1rx_word_t reg_rdata;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic pos = 1'h0;
	logic neg = 1'h0;
	logic rec = 1'h0;
	logic mref = 1'h0;
	logic tclk = 1'h0;
	logic absent = 1'h0;
	logic pol = 1'h0;
	logic ref_en = 1'h1;
	logic tclk_en = 1'h1;
	logic gen_on = 1'h0;
	logic man_pos = 1'h0;
	logic man_neg = 1'h0;
	logic rd_o, cv_o, rp_o, rn_o, rclk_o, los_o, tmiss_o, hiz_o, txsel_o, txclk_o;
	int cyc = 0;
	int nbit = 0;
	int inj_bit = -1;
	int ones, errs, o0, e0;
	int miscompares = 0;
	int checks = 0;

	always #5 clk = !clk;

	e1rx_top u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_pos_in(pos), .line_neg_in(neg), .recovered_clock_in(rec),
		.ref_clock_in(mref), .transmit_clock_in(tclk), .signal_absent_in(absent), .received_data_out(rd_o),
		.violation_flag_out(cv_o), .positive_rail_out(rp_o), .negative_rail_out(rn_o),
		.receive_clock_out(rclk_o), .signal_lost_out(los_o), .transmit_clock_missing_out(tmiss_o),
		.line_driver_hiz_out(hiz_o), .tx_bit_clock_out(txclk_o), .tx_ref_select_out(txsel_o));

	e1rx_sys_model u_sys (.clk(clk), .rclk(rclk_o), .rd(rd_o), .cv(cv_o), .ones(ones), .errs(errs));

	// line, recovered clock 160 ns, reference 480 ns, transmit clock
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7)
		begin
			rec <= !rec;
			if (rec)
			begin
				nbit <= nbit + 1;
				if (nbit != inj_bit)
					pol <= !pol;
			end
		end
		if (ref_en && cyc % 24 == 23)
			mref <= !mref;
		if (tclk_en && cyc % 12 == 5)
			tclk <= !tclk;
		pos <= gen_on ? pol : man_pos;
		neg <= gen_on ? !pol : man_neg;
	end

	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check_word(input e1rx_word_t got, input e1rx_word_t exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task check_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task wr_reg(input e1rx_addr_t a, input e1rx_word_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask

	task rd_reg(input e1rx_addr_t a, input e1rx_word_t exp);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 check_word(reg_rdata, exp);
		@(posedge clk);
	endtask

	initial
	begin
		#150us;
		miscompares++;
		stop_test;
	end

	initial
	begin
		wt(20);
		arst_n <= 1'h1;
		wt(1);
		rd_reg(8'h00, 32'h017);
		rd_reg(8'h08, 32'h0);
		wr_reg(8'h04, 32'hffffffff);
		rd_reg(8'h04, 32'h0);
		absent <= 1'h1;
		wt(6);
		check_bit(los_o, 1'h1);
		wr_reg(8'h00, 32'h01d);
		wt(1);
		check_bit(txsel_o, 1'h1);
		@(posedge mref);
		wt(6);
		check_bit(rclk_o, 1'h1);
		@(negedge mref);
		wt(6);
		check_bit(rclk_o, 1'h0);
		absent <= 1'h0;
		wt(6);
		check_bit(los_o, 1'h0);
		tclk_en <= 1'h0;
		wt(60 * 48);
		check_bit(tmiss_o, 1'h0);
		wt(15 * 48);
		check_bit(tmiss_o, 1'h1);
		rd_reg(8'h04, 32'h2);
		tclk_en <= 1'h1;
		wt(40);
		check_bit(tmiss_o, 1'h0);
		wr_reg(8'h00, 32'h015);
		gen_on <= 1'h1;
		wt(200);
		o0 = ones;
		e0 = errs;
		inj_bit <= nbit + 5;
		wt(64 * 16);
		check_bit(errs - e0 == 1, 1'h1);
		check_bit(ones - o0 >= 55, 1'h1);
		gen_on <= 1'h0;
		man_pos <= 1'h1;
		wr_reg(8'h00, 32'h000);
		wt(6);
		check_bit(rp_o, 1'h1);
		check_bit(rn_o, 1'h0);
		check_bit(rclk_o, 1'h1);
		wr_reg(8'h00, 32'h020);
		wt(6);
		check_bit(rp_o, 1'h0);
		check_bit(rn_o, 1'h1);
		ref_en <= 1'h0;
		wt(160);
		check_bit(hiz_o, 1'h1);
		rd_reg(8'h04, 32'h4);
		wr_reg(8'h00, 32'h080);
		wt(6);
		check_bit(txsel_o, 1'h1);
		check_bit(txclk_o, mref);
		stop_test;
	end
endmodule

//--- verilog/e1rx_consts.svh
`ifndef E1RX_CONSTS_SVH
`define E1RX_CONSTS_SVH

// register offsets
`define E1RX_CTRL_OFS 8'h00
`define E1RX_STAT_OFS 8'h04

// control register fields
`define E1RX_CTRL_W 11
`define E1RX_CTRL_RST 11'h017
`define E1RX_B_SINGLE 0
`define E1RX_B_HDB3 1
`define E1RX_B_CDR 2
`define E1RX_B_ALARM_SUBSTITUTE_ENABLE 3
`define E1RX_B_RISE 4
`define E1RX_B_INV 5
`define E1RX_B_HWMODE 6
`define E1RX_B_TAO 7
`define E1RX_B_PRBS 8
`define E1RX_B_AUTO_ALL_ONES_ON_LOSS 9
`define E1RX_B_ZEROS 10

// status register fields
`define E1RX_S_LOS 0
`define E1RX_S_TCLK_MISS 1
`define E1RX_S_MCLK_LOSS 2

// timing
`define E1RX_TCLK_MISS_CYC 7'h46
`define E1RX_TCLK_CNT_MAX 7'h7f
`define E1RX_CLK_MHZ 100
`define E1RX_MCLK_LOSS_NS 1000
`define E1RX_MCLK_LOSS_CYC ((`E1RX_MCLK_LOSS_NS * `E1RX_CLK_MHZ + 999) / 1000)
`define E1RX_MCLK_CNT_MAX 8'hff

// zero run limits, count of zeros before the one that flags
`define E1RX_EXZ_HDB3 4'h3
`define E1RX_EXZ_AMI 4'h7
`define E1RX_ZRUN_MAX 4'hf

// synchroniser bundle positions
`define E1RX_SY_POS 0
`define E1RX_SY_NEG 1
`define E1RX_SY_REC 2
`define E1RX_SY_MCLK 3
`define E1RX_SY_TCLK 4
`define E1RX_SY_LOS 5
`define E1RX_SY_W 6

`endif

//--- verilog/e1rx_pkg.sv
package e1rx_pkg;
	typedef logic [7:0] e1rx_addr_t;
	typedef logic [31:0] e1rx_word_t;

	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
	} e1rx_sync_t;

	typedef struct packed {
		logic [10:0] ctrl;
		logic [31:0] rdata;
		logic tclk_p;
		logic mclk_p;
		logic src_p;
		logic [6:0] tclk_cnt;
		logic tclk_miss;
		logic [7:0] mclk_cnt;
		logic mclk_lost;
		logic have_mark;
		logic last_pol;
		logic have_v;
		logic last_v_pol;
		logic [3:0] zrun;
		logic [3:0] sh;
		logic [3:0] cvsh;
		logic head_bit;
		logic head_cv;
		logic pos_r;
		logic neg_r;
		logic rd;
		logic cv;
		logic rp;
		logic rn;
		logic rclk;
		logic los;
		logic hiz;
		logic txref;
		logic txclk;
	} e1rx_state_t;
endpackage

//--- verilog/e1rx_sync.sv
`timescale 1ns/100ps
module e1rx_sync
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [5:0] d,
	output logic [5:0] q
);
	import e1rx_pkg::*;

	e1rx_sync_t st_q;
	e1rx_sync_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign q = st_q.s2;
endmodule

//--- verilog/e1rx_top.sv
// Behaviour
// RL1: transmit clock stuck over 70 reference cycles: missing
// RL2: single rail: NRZ data, AMI or HDB3 decoded
// RL3: violation held high one receive clock period
// RL4: HDB3 reports code violations, AMI bipolar violations
// RL5: hardware mode single rail adds excess zeros
// RL6: dual rail: retimed NRZ, raw RZ when bypassed
// RL7: selectable launch edge and data active level
// RL8: receive clock output per channel, 2.048 MHz
// RL9: recovery mode, loss plus substitute enable: clock from reference
// RL10: recovery mode: recovered clock, data on edge
// RL11: recovery bypassed: clock is rail XOR
// RL12: reference clock is timing base
// RL13: patterns and auto all ones use reference clock
// RL14: hardware mode all ones or PRBS: reference clock
// RL15: reference clock lost: line drivers high impedance
// RL16: loss output follows received signal loss
// RL17: system samples opposite edge, flag means error
// RL18: violation flag launched with its data bit
`timescale 1ns/100ps
`include "e1rx_consts.svh"
module e1rx_top
(
	input wire logic clk,
	input wire logic arst_n,
	input wire e1rx_pkg::e1rx_addr_t reg_addr,
	input wire e1rx_pkg::e1rx_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output e1rx_pkg::e1rx_word_t reg_rdata,
	input wire logic line_pos_in,
	input wire logic line_neg_in,
	input wire logic recovered_clock_in,
	input wire logic ref_clock_in,
	input wire logic transmit_clock_in,
	input wire logic signal_absent_in,
	output logic received_data_out,
	output logic violation_flag_out,
	output logic positive_rail_out,
	output logic negative_rail_out,
	output logic receive_clock_out,
	output logic signal_lost_out,
	output logic transmit_clock_missing_out,
	output logic line_driver_hiz_out,
	output logic tx_bit_clock_out,
	output logic tx_ref_select_out
);
	import e1rx_pkg::*;

	e1rx_state_t st_q;
	e1rx_state_t st_d;
	logic [5:0] sy;
	logic pos_s;
	logic neg_s;
	logic rec_s;
	logic mclk_s;
	logic tclk_s;
	logic los_s;
	logic mclk_rise;
	logic subst;
	logic src;
	logic sample;
	logic launch;
	logic mark;
	logic bpv;
	logic cv_code;
	logic excess_zeros_error;
	logic flag;
	logic wr_hit;
	logic txref;
	logic [3:0] exz_lim;

	e1rx_sync u_sync
	(
		.clk(clk),
		.arst_n(arst_n),
		.d({signal_absent_in, transmit_clock_in, ref_clock_in, recovered_clock_in, line_neg_in, line_pos_in}),
		.q(sy)
	);

	assign pos_s = sy[`E1RX_SY_POS];
	assign neg_s = sy[`E1RX_SY_NEG];
	assign rec_s = sy[`E1RX_SY_REC];
	assign mclk_s = sy[`E1RX_SY_MCLK];
	assign tclk_s = sy[`E1RX_SY_TCLK];
	assign los_s = sy[`E1RX_SY_LOS];

	always_comb
	begin
		st_d = st_q;
		mclk_rise = mclk_s & ~st_q.mclk_p;
		wr_hit = reg_wr & (reg_addr == `E1RX_CTRL_OFS);
		subst = st_q.ctrl[`E1RX_B_ALARM_SUBSTITUTE_ENABLE] & st_q.los;
		// receive clock source
		if (!st_q.ctrl[`E1RX_B_CDR])
			src = pos_s ^ neg_s; // RL11
		else if (subst)
			src = mclk_s; // RL9
		else
			src = rec_s; // RL10
		sample = src & ~st_q.src_p;
		launch = st_q.ctrl[`E1RX_B_RISE] ? (src & ~st_q.src_p) : (~src & st_q.src_p); // RL7
		mark = pos_s | neg_s;
		bpv = mark & st_q.have_mark & (pos_s == st_q.last_pol);
		cv_code = bpv & st_q.have_v & (pos_s == st_q.last_v_pol);
		exz_lim = st_q.ctrl[`E1RX_B_HDB3] ? `E1RX_EXZ_HDB3 : `E1RX_EXZ_AMI;
		excess_zeros_error = ~mark & (st_q.zrun == exz_lim);
		flag = (st_q.ctrl[`E1RX_B_HDB3] ? cv_code : bpv) // RL4
			| (excess_zeros_error & st_q.ctrl[`E1RX_B_HWMODE]); // RL5
		txref = st_q.ctrl[`E1RX_B_TAO] | st_q.ctrl[`E1RX_B_PRBS] | st_q.ctrl[`E1RX_B_ZEROS]
			| (st_q.ctrl[`E1RX_B_AUTO_ALL_ONES_ON_LOSS] & st_q.los) | subst; // RL13 RL14

		// register port
		if (wr_hit)
			st_d.ctrl = reg_wdata[`E1RX_CTRL_W-1:0];
		st_d.rdata = '0;
		if (reg_rd && reg_addr == `E1RX_CTRL_OFS)
			st_d.rdata[`E1RX_CTRL_W-1:0] = st_q.ctrl;
		else if (reg_rd && reg_addr == `E1RX_STAT_OFS)
		begin
			st_d.rdata[`E1RX_S_LOS] = st_q.los;
			st_d.rdata[`E1RX_S_TCLK_MISS] = st_q.tclk_miss;
			st_d.rdata[`E1RX_S_MCLK_LOSS] = st_q.mclk_lost;
		end

		st_d.src_p = src;
		st_d.mclk_p = mclk_s;
		st_d.tclk_p = tclk_s;

		// transmit clock watchdog counted in reference cycles
		if (tclk_s != st_q.tclk_p)
		begin
			st_d.tclk_cnt = '0;
			st_d.tclk_miss = 1'h0;
		end
		else if (mclk_rise)
		begin
			if (st_q.tclk_cnt != `E1RX_TCLK_CNT_MAX)
				st_d.tclk_cnt = st_q.tclk_cnt + 7'h01;
			if (st_q.tclk_cnt >= `E1RX_TCLK_MISS_CYC)
				st_d.tclk_miss = 1'h1; // RL1
		end

		// reference clock watchdog
		if (mclk_rise)
			st_d.mclk_cnt = '0; // RL12
		else if (st_q.mclk_cnt != `E1RX_MCLK_CNT_MAX)
			st_d.mclk_cnt = st_q.mclk_cnt + 8'h01;
		st_d.mclk_lost = (st_q.mclk_cnt >= 8'(`E1RX_MCLK_LOSS_CYC));
		st_d.hiz = st_q.mclk_lost; // RL15

		// decoder, one step per line bit
		if (sample)
		begin
			st_d.head_bit = st_q.sh[3];
			st_d.head_cv = st_q.cvsh[3];
			st_d.pos_r = pos_s;
			st_d.neg_r = neg_s;
			st_d.sh = {st_q.sh[2:0], mark}; // RL2
			st_d.cvsh = {st_q.cvsh[2:0], flag};
			if (mark)
			begin
				st_d.have_mark = 1'h1;
				st_d.last_pol = pos_s;
				st_d.zrun = '0;
			end
			else if (st_q.zrun != `E1RX_ZRUN_MAX)
				st_d.zrun = st_q.zrun + 4'h1;
			if (bpv && st_q.ctrl[`E1RX_B_HDB3])
			begin
				st_d.sh = 4'h0; // RL2
				st_d.have_v = 1'h1;
				st_d.last_v_pol = pos_s;
			end
		end

		// output stage
		if (!st_q.ctrl[`E1RX_B_SINGLE] && !st_q.ctrl[`E1RX_B_CDR])
		begin
			st_d.rp = pos_s ^ st_q.ctrl[`E1RX_B_INV]; // RL6
			st_d.rn = neg_s ^ st_q.ctrl[`E1RX_B_INV];
		end
		if (launch)
		begin
			if (st_q.ctrl[`E1RX_B_SINGLE])
			begin
				st_d.rd = st_q.head_bit ^ st_q.ctrl[`E1RX_B_INV]; // RL2 RL7
				st_d.cv = st_q.head_cv; // RL3 RL18
			end
			else if (st_q.ctrl[`E1RX_B_CDR])
			begin
				st_d.rp = st_q.pos_r ^ st_q.ctrl[`E1RX_B_INV]; // RL6 RL10
				st_d.rn = st_q.neg_r ^ st_q.ctrl[`E1RX_B_INV];
			end
		end
		if (!st_q.ctrl[`E1RX_B_SINGLE])
		begin
			st_d.rd = 1'h0;
			st_d.cv = 1'h0;
		end
		else
		begin
			st_d.rp = 1'h0;
			st_d.rn = 1'h0;
		end
		st_d.rclk = src; // RL8
		st_d.los = los_s; // RL16
		st_d.txref = txref;
		st_d.txclk = txref ? mclk_s : tclk_s; // RL13
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= '0;
			st_q.ctrl <= `E1RX_CTRL_RST;
		end
		else
			st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign received_data_out = st_q.rd;
	assign violation_flag_out = st_q.cv;
	assign positive_rail_out = st_q.rp;
	assign negative_rail_out = st_q.rn;
	assign receive_clock_out = st_q.rclk;
	assign signal_lost_out = st_q.los;
	assign transmit_clock_missing_out = st_q.tclk_miss;
	assign line_driver_hiz_out = st_q.hiz;
	assign tx_bit_clock_out = st_q.txclk;
	assign tx_ref_select_out = st_q.txref;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_tclk_miss_set: assert property ((mclk_rise && tclk_s == st_q.tclk_p && st_q.tclk_cnt == `E1RX_TCLK_MISS_CYC)
		|=> transmit_clock_missing_out) else $error("transmit clock loss not flagged"); // RL1
	a_tclk_miss_clear: assert property ((tclk_s != st_q.tclk_p) |=> !transmit_clock_missing_out)
		else $error("transmit clock loss kept after activity"); // RL1
	a_cv_hold_period: assert property ((!$past(launch) && !$past(wr_hit) && !$past(wr_hit, 2))
		|-> $stable(violation_flag_out)) else $error("violation flag moved between launch edges"); // RL3
	a_hdb3_cv_flag: assert property ((sample && st_q.ctrl[`E1RX_B_HDB3] && cv_code) |=> st_q.cvsh[0])
		else $error("hdb3 code violation not recorded"); // RL4
	a_ami_bpv_flag: assert property ((sample && !st_q.ctrl[`E1RX_B_HDB3] && bpv) |=> st_q.cvsh[0])
		else $error("bipolar violation not recorded"); // RL4
	a_dual_no_cv: assert property (!st_q.ctrl[`E1RX_B_SINGLE] |=> !violation_flag_out)
		else $error("violation flag high in dual rail"); // RL6
	a_rclk_subst: assert property ((st_q.ctrl[`E1RX_B_CDR] && subst) |=> receive_clock_out == $past(mclk_s))
		else $error("receive clock not from reference during loss"); // RL9
	a_rclk_recov: assert property ((st_q.ctrl[`E1RX_B_CDR] && !subst) |=> receive_clock_out == $past(rec_s))
		else $error("receive clock not recovered clock"); // RL10
	a_rclk_xor: assert property (!st_q.ctrl[`E1RX_B_CDR] |=> receive_clock_out == $past(pos_s ^ neg_s))
		else $error("bypass receive clock not rail xor"); // RL11
	a_hiz_ref_loss: assert property ((st_q.mclk_cnt >= 8'(`E1RX_MCLK_LOSS_CYC)) |-> ##2 line_driver_hiz_out)
		else $error("drivers not high impedance on reference loss"); // RL15
	a_tx_ref_clk: assert property (st_q.ctrl[`E1RX_B_TAO] |=> tx_ref_select_out && tx_bit_clock_out == $past(mclk_s))
		else $error("all ones not clocked from reference"); // RL13 RL14
	a_los_follow: assert property ($rose(los_s) |=> signal_lost_out ##0 $past(los_s) == signal_lost_out)
		else $error("loss output not following signal loss"); // RL16

	c_tclk_missing: cover property ($rose(transmit_clock_missing_out));
	c_violation: cover property ($rose(violation_flag_out) ##1 violation_flag_out);
	c_loss_subst: cover property (subst && st_q.ctrl[`E1RX_B_CDR] ##1 $rose(receive_clock_out));
	c_ref_lost: cover property ($rose(line_driver_hiz_out));
endmodule
